// file: rtl/supply_monitor_reset_ctrl.sv
// supply monitor sampling, status flags, shutdown pin and core reset sequencing
// assumes mclk is the slow clock; comparator and brownout inputs are asynchronous
`timescale 1ns/1ps
`include "supply_monitor_cfg.svh"
module supply_monitor_reset_ctrl
  import supply_monitor_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire monitor_mode_t monitor_mode_register,
  input  wire logic          monitor_wakeup_enable,
  input  wire logic          brownout_reset_enable,
  input  wire logic          regulator_off_request,
  input  wire logic          status_read,
  input  wire logic          other_wakeup,
  input  wire logic          monitor_comp_in,
  input  wire logic          brownout_in,
  input  wire logic          core_regulated,
  output logic [3:0]         comparator_threshold,
  output logic               comparator_enable,
  output logic               monitor_live_output,
  output logic               monitor_sticky_flag,
  output logic               irq,
  output logic               wakeup_event,
  output logic               shutdown_out_n,
  output logic               core_reset_n,
  output logic               core_shutdown_ok
);
  // ***************************************************
  // sampling
  // ***************************************************
  logic [10:0] div_cnt;
  logic [10:0] div_last;
  logic        continuous;
  logic        sample_tick;
  logic        comp_meta;
  logic        comp_sync;
  logic        bod_meta;
  logic        bod_sync;
  logic        detect;
  logic        sample_window;
  logic        sample_stage;
  pwr_state_t  pwr_state;

  assign continuous = (monitor_mode_register.sample_period_select == `SMPL_CONT);
  always_comb begin
    unique case (monitor_mode_register.sample_period_select)
      `SMPL_32:   div_last = `DIV_32_LAST;
      `SMPL_256:  div_last = `DIV_256_LAST;
      `SMPL_2048: div_last = `DIV_2048_LAST;
      `SMPL_CONT: div_last = `DIV_ZERO;
    endcase
  end

  // in duty mode a dip shorter than the sample period can go unseen;
  // that is the price of the lower comparator power
  // duty cycle divider
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= `DIV_ZERO;
    end else if (continuous || div_cnt >= div_last) begin
      div_cnt <= `DIV_ZERO;
    end else begin
      div_cnt <= div_cnt + `DIV_ONE;
    end
  end
  assign sample_tick = continuous || (div_cnt == `DIV_ZERO);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      comparator_threshold <= 4'h0;
      comparator_enable    <= 1'b0;
    end else begin
      comparator_threshold <= monitor_mode_register.threshold_select;
      comparator_enable    <= sample_tick;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
      bod_meta  <= 1'b0;
      bod_sync  <= 1'b0;
    end else begin
      comp_meta <= monitor_comp_in;
      comp_sync <= comp_meta;
      bod_meta  <= brownout_in;
      bod_sync  <= bod_meta;
    end
  end

  // the powered cycle is judged once its result has crossed both sync
  // stages; one stage less would judge the comparator while still off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sample_stage  <= 1'b0;
      sample_window <= 1'b0;
    end else begin
      sample_stage  <= comparator_enable;
      sample_window <= sample_stage;
    end
  end

  // a result only counts while the comparator was powered for it
  assign detect = comp_sync && (continuous || sample_window);

  // ***************************************************
  // status
  // ***************************************************
  // live result refresh
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_live_output <= 1'b0;
    end else if (continuous || sample_window) begin
      monitor_live_output <= comp_sync;
    end
  end

  // sticky, set wins over read clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_sticky_flag <= 1'b0;
    end else if (detect) begin
      monitor_sticky_flag <= 1'b1;
    end else if (status_read) begin
      monitor_sticky_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (monitor_sticky_flag || detect) && monitor_mode_register.monitor_irq_enable;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wakeup_event <= 1'b0;
    end else begin
      wakeup_event <= (detect && monitor_wakeup_enable) || other_wakeup;
    end
  end

  // ***************************************************
  // power sequencing
  // ***************************************************
  logic reset_cause;
  assign reset_cause = (detect && monitor_mode_register.monitor_reset_enable)
                     || (bod_sync && brownout_reset_enable);

  // an off request wins over a pending reset so the regulator can always be shut down
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_state <= pwr_reset_hold;
    end else begin
      unique case (pwr_state)
        pwr_run: begin
          if (regulator_off_request) begin
            pwr_state <= pwr_backup;
          end else if (reset_cause) begin
            pwr_state <= pwr_reset_hold;
          end
        end
        pwr_reset_hold: begin
          if (regulator_off_request) begin
            pwr_state <= pwr_backup;
          end else if (core_regulated && !reset_cause) begin
            pwr_state <= pwr_run;
          end
        end
        pwr_backup: begin
          if (wakeup_event) begin
            pwr_state <= pwr_reset_hold;
          end
        end
        // the unused code falls back to holding the core in reset
        default: begin
          pwr_state <= pwr_reset_hold;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_out_n <= 1'b1;
    end else if (pwr_state == pwr_backup) begin
      shutdown_out_n <= wakeup_event;
    end else begin
      shutdown_out_n <= !regulator_off_request;
    end
  end

  // reset held across shutdown and until regulated
  // reset within one cycle of synced detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= (pwr_state == pwr_run) && !reset_cause && !regulator_off_request;
    end
  end

  // backup confirmation for the far side, only once the core is held
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_shutdown_ok <= 1'b0;
    end else begin
      core_shutdown_ok <= (pwr_state == pwr_backup) && !core_reset_n;
    end
  end
endmodule

// file: common/supply_monitor_cfg.svh
// constants for the supply monitor and reset control block
// assumes one slow clock domain (mclk); all settings arrive as plain ports
`ifndef SUPPLY_MONITOR_CFG_SVH
`define SUPPLY_MONITOR_CFG_SVH
// threshold code 0 = 1.9V, each step 100 mV, last code 15 = 3.4V
`define THRESH_MIN_MV    1900
`define THRESH_STEP_MV   100
`define THRESH_MAX_CODE  4'hF
// sample period codes
`define SMPL_CONT        2'h0
`define SMPL_32          2'h1
`define SMPL_256         2'h2
`define SMPL_2048        2'h3
// sample divider terminal values (period minus one)
`define DIV_32_LAST      11'h01F
`define DIV_256_LAST     11'h0FF
`define DIV_2048_LAST    11'h7FF
`define DIV_ZERO         11'h000
`define DIV_ONE          11'h001
`endif

// file: common/supply_monitor_pkg.sv
// types for the supply monitor and reset control block
// assumes the cfg header supplies all numeric constants
package supply_monitor_pkg;
  typedef struct packed {
    logic [3:0] threshold_select;
    logic [1:0] sample_period_select;
    logic       monitor_reset_enable;
    logic       monitor_irq_enable;
  } monitor_mode_t;
  typedef enum logic [1:0] {
    pwr_run,
    pwr_reset_hold,
    pwr_backup
  } pwr_state_t;
endpackage

// file: bench/supply_monitor_reset_ctrl_sva.sv
// port checks for the supply monitor block
// assumes one clock domain, bound to the design top
`timescale 1ns/1ps
`include "supply_monitor_cfg.svh"
module supply_monitor_sva
  import supply_monitor_pkg::*;
(
  input wire logic          mclk,
  input wire logic          reset_n,
  input wire monitor_mode_t monitor_mode_register,
  input wire logic          monitor_wakeup_enable,
  input wire logic          regulator_off_request,
  input wire logic          status_read,
  input wire logic          monitor_comp_in,
  input wire logic          comparator_enable,
  input wire logic          monitor_sticky_flag,
  input wire logic          irq,
  input wire logic          wakeup_event,
  input wire logic          shutdown_out_n,
  input wire logic          core_reset_n
);
  // ****
  // checks
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire cont = monitor_mode_register.sample_period_select == `SMPL_CONT;
  wire ie   = monitor_mode_register.monitor_irq_enable;
  wire re   = monitor_mode_register.monitor_reset_enable;
  a_sticky_hold: assert property (monitor_sticky_flag && !status_read |=> monitor_sticky_flag)
    else $error("sticky flag lost");
  a_irq_follow: assert property ($rose(monitor_sticky_flag) && ie && $past(ie) |-> irq)
    else $error("irq missing");
  a_shutdown_out_n_low: assert property ($rose(regulator_off_request) && !wakeup_event |=> !shutdown_out_n)
    else $error("shutdown not driven");
  a_shutdown_out_n_release: assert property (!shutdown_out_n && wakeup_event |=> shutdown_out_n)
    else $error("shutdown not released");
  a_reset_first: assert property ($fell(shutdown_out_n) |-> !core_reset_n)
    else $error("core reset late");
  a_reset_delay: assert property ($rose(monitor_comp_in) && re && cont |-> ##[1:4] !core_reset_n)
    else $error("reset not raised");
  a_wake_event: assert property ($rose(monitor_comp_in) && monitor_wakeup_enable && cont
    |-> ##[1:4] wakeup_event)
    else $error("wakeup missing");
  a_cont_enable: assert property (cont [*3] |-> comparator_enable)
    else $error("comparator off");
endmodule
bind supply_monitor_reset_ctrl supply_monitor_sva i_supply_monitor_sva (.mclk, .reset_n,
  .monitor_mode_register, .monitor_wakeup_enable, .regulator_off_request, .status_read,
  .monitor_comp_in, .comparator_enable, .monitor_sticky_flag, .irq, .wakeup_event,
  .shutdown_out_n, .core_reset_n);

// file: bench/regulator_model.sv
// external regulator model for the bench
// assumes shutdown_out_n high enables the regulator
`timescale 1ns/1ps
module regulator_model #(parameter int RAMP = 6) (
  input  wire logic mclk,
  input  wire logic shutdown_out_n,
  output logic      core_regulated
);
  // ****
  // ramp
  // ****
  int cnt = 0;
  always @(posedge mclk) begin
    cnt <= shutdown_out_n ? ((cnt < RAMP) ? cnt + 1 : cnt) : 0;
    core_regulated <= shutdown_out_n && cnt == RAMP;
  end
endmodule

// file: bench/supply_monitor_reset_ctrl_bench.sv
// self-checking bench for the supply monitor block
// assumes the regulator model closes the shutdown loop
`timescale 1ns/1ps
module supply_monitor_reset_ctrl_bench import supply_monitor_pkg::*;;
  logic          mclk = 1'h0, reset_n = 1'h0, status_read = 1'h0, other_wakeup = 1'h0;
  logic          monitor_wakeup_enable = 1'h1, brownout_reset_enable = 1'h0;
  logic          regulator_off_request = 1'h0, monitor_comp_in = 1'h0, brownout_in = 1'h0;
  monitor_mode_t monitor_mode_register = '{4'hF, 2'h0, 1'h1, 1'h1};
  logic [3:0]    comparator_threshold;
  logic          core_regulated, comparator_enable, monitor_live_output, monitor_sticky_flag;
  logic          irq, wakeup_event, shutdown_out_n, core_reset_n, core_shutdown_ok;
  int            num_errors = 0, total_checks = 0, n;
  supply_monitor_reset_ctrl i_supply_monitor_reset_ctrl (.mclk, .reset_n, .monitor_mode_register,
    .monitor_wakeup_enable, .brownout_reset_enable, .regulator_off_request, .status_read,
    .other_wakeup, .monitor_comp_in, .brownout_in, .core_regulated, .comparator_threshold,
    .comparator_enable, .monitor_live_output, .monitor_sticky_flag, .irq, .wakeup_event,
    .shutdown_out_n, .core_reset_n, .core_shutdown_ok);
  regulator_model i_regulator_model (.mclk, .shutdown_out_n, .core_regulated);
  initial forever #20 mclk = ~mclk;
  // ****
  // tasks
  // ****
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic test_done;
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait until the core leaves reset
  task automatic wait_run;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (core_reset_n !== 1'h1 && n < 200);
    if (n == 200) begin
      num_errors++;
      test_done();
    end
    @(posedge mclk);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    cyc(2);
    reset_n <= 1'h1;
    wait_run();
    monitor_comp_in <= 1'h1;
    cyc(3);
    @(negedge mclk);
    chk(wakeup_event, 1'h1);
    cyc(2);
    @(negedge mclk);
    chk({core_reset_n, monitor_sticky_flag, irq, monitor_live_output}, 4'h7);
    chk(comparator_threshold, 4'hF);
    cyc(1);
    monitor_comp_in <= 1'h0;
    cyc(5);
    @(negedge mclk);
    chk({monitor_live_output, monitor_sticky_flag}, 2'h1);
    cyc(1);
    status_read <= 1'h1;
    cyc(1);
    status_read <= 1'h0;
    cyc(2);
    @(negedge mclk);
    chk({monitor_sticky_flag, irq}, 2'h0);
    cyc(1);
    monitor_mode_register <= '{4'h0, 2'h0, 1'h0, 1'h1};
    monitor_wakeup_enable <= 1'h0;
    wait_run();
    monitor_comp_in <= 1'h1;
    cyc(3);
    @(negedge mclk);
    chk(wakeup_event, 1'h0);
    cyc(2);
    @(negedge mclk);
    chk({core_reset_n, monitor_sticky_flag, irq}, 3'h7);
    chk(comparator_threshold, 4'h0);
    cyc(1);
    monitor_comp_in <= 1'h0;
    // one enable pulse per period, counted over two periods
    for (int k = 1; k < 4; k++) begin
      monitor_mode_register.sample_period_select <= 2'(k);
      cyc(4);
      n = 0;
      repeat (64 << (3 * k - 3)) begin
        @(negedge mclk);
        n += comparator_enable;
      end
      chk(n[3:0], 4'h2);
      @(posedge mclk);
    end
    monitor_mode_register.sample_period_select <= 2'h0;
    regulator_off_request <= 1'h1;
    cyc(2);
    @(negedge mclk);
    chk({shutdown_out_n, core_reset_n, core_shutdown_ok}, 3'h1);
    cyc(1);
    regulator_off_request <= 1'h0;
    other_wakeup <= 1'h1;
    cyc(1);
    other_wakeup <= 1'h0;
    cyc(2);
    @(negedge mclk);
    chk({shutdown_out_n, core_shutdown_ok}, 2'h2);
    wait_run();
    brownout_reset_enable <= 1'h1;
    brownout_in <= 1'h1;
    cyc(5);
    @(negedge mclk);
    chk(core_reset_n, 1'h0);
    cyc(1);
    brownout_in <= 1'h0;
    wait_run();
    test_done();
  end
endmodule
